//--- rtl/pci_agent_map.svh
// Constants for the primary bus agent: commands, timing counts and pin routing codes.
`ifndef PCI_AGENT_MAP_SVH
`define PCI_AGENT_MAP_SVH
`define CMD_IO_READ        4'h2
`define CMD_IO_WRITE       4'h3
`define CMD_MEM_READ       4'h6
`define CMD_MEM_WRITE      4'h7
`define CMD_CFG_READ       4'ha
`define CMD_CFG_WRITE      4'hb
`define PERR_RESP_BIT      6
`define ABORT_TIMEOUT      3'h5
`define MFP7_ROUTE_LOCK    4'h7
`endif

//--- rtl/pci_agent_pkg.sv
// Types shared by the primary bus agent.
package pci_agent_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WAITSEL, ST_DATA, ST_ABORT, ST_TURN} mst_state_t;
   typedef enum logic [1:0] {TS_IDLE, TS_DATA, TS_TURN} tgt_state_t;
endpackage : pci_agent_pkg

//--- rtl/pci_primary_agent.sv
// Primary bus agent: target claim, initiator sequencing, parity and lock pin.
// Functional notes
// - Address/data lines carry 32-bit address in address phase, data after.
// - Command/byte-enable lines carry command, then byte enables per data phase.
// - Byte enable n qualifies data lane n, lane 0 lowest.
// - Even parity computed over all address/data and command/byte-enable bits.
// - As initiator, parity is driven one clock after its phase.
// - As target, mismatching parity raises the parity error signal.
// - Device select asserted whenever this agent decodes itself as target.
// - Unclaimed initiator cycle ends with initiator abort after timeout.
// - Initiator asserts frame to start and holds it while more data follows.
// - Deasserted frame marks the final data phase for initiator and target.
// - A grant without a preceding request is accepted (bus parking).
// - Lock only available when multifunction pin 7 routing selects it.
// - Configured lock gives exclusive access to downstream resources.
// - Parity error driven only while command bit 6 enables it.
// - Bus request asserted whenever the agent needs to be initiator.
// - Data phase completes only when both ready signals are sampled asserted.
// - All bus signals are sampled on the rising bus clock edge.
`timescale 1ns/100ps
`include "pci_agent_map.svh"
module pci_primary_agent
   import pci_agent_pkg::*;
#(
   parameter logic [31:0] BASE_ADDR = 32'h8000_0000,
   parameter logic [31:0] ADDR_MASK = 32'hffff_f000
)
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [31:0] adIn,
   output logic      [31:0] adOut,
   output logic             adOe,
   input  wire logic [3:0]  cbeIn,
   output logic      [3:0]  cbeOut,
   output logic             cbeOe,
   input  wire logic        parIn,
   output logic             parOut,
   output logic             parOe,
   input  wire logic        frameIn_n,
   output logic             frameOut_n,
   output logic             frameOe,
   input  wire logic        irdyIn_n,
   output logic             irdyOut_n,
   output logic             irdyOe,
   input  wire logic        trdyIn_n,
   output logic             trdyOut_n,
   output logic             trdyOe,
   input  wire logic        devselIn_n,
   output logic             devselOut_n,
   output logic             devselOe,
   output logic             perrOut_n,
   output logic             perrOe,
   output logic             req_n,
   input  wire logic        gnt_n,
   input  wire logic        multifunction_pin_7In,
   output logic             multifunction_pin_7Out,
   output logic             multifunction_pin_7Oe,
   input  wire logic [3:0]  mfp7Route,
   input  wire logic [15:0] cmdReg,
   input  wire logic        mstStart,
   input  wire logic [3:0]  mstCmd,
   input  wire logic [31:0] mstAddr,
   input  wire logic [31:0] mstWdata,
   input  wire logic [3:0]  mstBe,
   input  wire logic        mstLockReq,
   output logic             mstBusy,
   output logic             mstDone,
   output logic             mstAbort,
   output logic [31:0]      mstRdata,
   output logic [31:0]      tgtWdata,
   output logic [3:0]       tgtBe,
   output logic             tgtWstb,
   input  wire logic [31:0] tgtRdata,
   output logic             lockHeld
);

////////////////////////////////////////////////////////////////////////////////

   mst_state_t mstState_ff;
   tgt_state_t tgtState_ff;
   logic [2:0]  selCnt_ff;
   logic        pend_ff;
   logic [3:0]  cmdHold_ff;
   logic [31:0] addrHold_ff;
   logic [31:0] wdataHold_ff;
   logic [3:0]  beHold_ff;
   logic        lockReq_ff;
   logic        tgtWrite_ff;
   logic        tgtLast_ff;
   logic        parCalc_ff;
   logic        parCheck_ff;
   logic        parDrive_ff;
   logic        perr_ff;
   logic        perrOe_ff;
   logic        busIdle;
   logic        hit;
   logic        lockMode;
   logic        mstAddrPh;
   logic        mstDataDrv;
   logic        tgtDrvData;
   logic        curPar;

   assign busIdle  = frameIn_n && irdyIn_n;
   assign curPar   = ^{adIn, cbeIn};
   assign lockMode = (mfp7Route == `MFP7_ROUTE_LOCK);
   assign hit = !frameIn_n && busIdle == 1'b0 && tgtState_ff == TS_IDLE &&
                mstState_ff == ST_IDLE && ((adIn & ADDR_MASK) == BASE_ADDR) &&
                (cbeIn == `CMD_MEM_READ || cbeIn == `CMD_MEM_WRITE);

////////////////////////////////////////////////////////////////////////////////

   // Request latch: the request stays up until our address phase goes out.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pend_ff      <= 1'b0;
         cmdHold_ff   <= 4'h0;
         addrHold_ff  <= 32'h0;
         wdataHold_ff <= 32'h0;
         beHold_ff    <= 4'h0;
         lockReq_ff   <= 1'b0;
      end
      else if (mstStart && !pend_ff && mstState_ff == ST_IDLE)
      begin
         pend_ff      <= 1'b1;
         cmdHold_ff   <= mstCmd;
         addrHold_ff  <= mstAddr;
         wdataHold_ff <= mstWdata;
         beHold_ff    <= mstBe;
         lockReq_ff   <= mstLockReq && lockMode;
      end
      else if (mstState_ff == ST_ADDR)
         pend_ff <= 1'b0;
   end

   assign req_n = !pend_ff;

   // Initiator sequencer; a parked grant is used the same as a requested one.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         mstState_ff <= ST_IDLE;
         selCnt_ff   <= 3'h0;
         mstDone     <= 1'b0;
         mstAbort    <= 1'b0;
         mstRdata    <= 32'h0;
      end
      else
      begin
         mstDone  <= 1'b0;
         mstAbort <= 1'b0;
         case (mstState_ff)
            ST_IDLE:
               if (pend_ff && !gnt_n && busIdle && tgtState_ff == TS_IDLE)
                  mstState_ff <= ST_ADDR;
            ST_ADDR:
            begin
               selCnt_ff   <= 3'h0;
               mstState_ff <= ST_WAITSEL;
            end
            ST_WAITSEL:
               // A fast target may be ready on the same edge it claims.
               if (!devselIn_n && !trdyIn_n)
               begin
                  mstRdata    <= adIn;
                  mstDone     <= 1'b1;
                  mstState_ff <= ST_TURN;
               end
               else if (!devselIn_n)
                  mstState_ff <= ST_DATA;
               else if (selCnt_ff == `ABORT_TIMEOUT)
                  mstState_ff <= ST_ABORT;
               else
                  selCnt_ff <= selCnt_ff + 3'h1;
            ST_DATA:
               if (!trdyIn_n)
               begin
                  mstRdata    <= adIn;
                  mstDone     <= 1'b1;
                  mstState_ff <= ST_TURN;
               end
            ST_ABORT:
            begin
               mstAbort    <= 1'b1;
               mstState_ff <= ST_TURN;
            end
            ST_TURN:
               mstState_ff <= ST_IDLE;
            default:
               mstState_ff <= ST_IDLE;
         endcase
      end
   end

   assign mstBusy    = pend_ff || mstState_ff != ST_IDLE;
   assign mstAddrPh  = mstState_ff == ST_ADDR;
   assign mstDataDrv = (mstState_ff == ST_WAITSEL || mstState_ff == ST_DATA) &&
                       cmdHold_ff[0];

   // address then data, byte enables by lane
   always_comb
   begin
      adOut  = tgtRdata;
      cbeOut = beHold_ff;
      if (mstAddrPh)
      begin
         adOut  = addrHold_ff;
         cbeOut = cmdHold_ff;
      end
      else if (mstDataDrv)
         adOut = wdataHold_ff;
   end
   assign adOe  = mstAddrPh || mstDataDrv || tgtDrvData;
   assign cbeOe = mstState_ff inside {ST_ADDR, ST_WAITSEL, ST_DATA};

   // single phase, frame drops at last
   assign frameOut_n = !mstAddrPh;
   assign frameOe    = mstState_ff inside {ST_ADDR, ST_WAITSEL, ST_DATA, ST_ABORT};
   assign irdyOut_n  = !(mstState_ff == ST_WAITSEL || mstState_ff == ST_DATA);
   assign irdyOe     = frameOe || mstState_ff == ST_TURN;

   assign lockHeld               = lockReq_ff && mstBusy;
   assign multifunction_pin_7Out = !(lockReq_ff && mstState_ff != ST_IDLE &&
                                     mstState_ff != ST_TURN);
   assign multifunction_pin_7Oe  = lockMode && lockReq_ff && mstState_ff != ST_IDLE;

////////////////////////////////////////////////////////////////////////////////

   // Target side: memory claim with fast device select, data phases until frame drops.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         tgtState_ff <= TS_IDLE;
         tgtWrite_ff <= 1'b0;
         tgtLast_ff  <= 1'b0;
         tgtWdata    <= 32'h0;
         tgtBe       <= 4'h0;
         tgtWstb     <= 1'b0;
      end
      else
      begin
         tgtWstb <= 1'b0;
         case (tgtState_ff)
            TS_IDLE:
               if (hit)
               begin
                  tgtWrite_ff <= cbeIn[0];
                  tgtState_ff <= TS_DATA;
               end
            TS_DATA:
               if (!irdyIn_n)
               begin
                  tgtLast_ff  <= frameIn_n;
                  tgtWdata    <= adIn;
                  tgtBe       <= cbeIn;
                  tgtWstb     <= tgtWrite_ff;
                  tgtState_ff <= frameIn_n ? TS_TURN : TS_DATA;
               end
            TS_TURN:
               tgtState_ff <= TS_IDLE;
            default:
               tgtState_ff <= TS_IDLE;
         endcase
      end
   end

   assign tgtDrvData  = tgtState_ff == TS_DATA && !tgtWrite_ff;
   assign devselOut_n = tgtState_ff != TS_DATA;
   assign trdyOut_n   = tgtState_ff != TS_DATA;
   assign devselOe    = tgtState_ff != TS_IDLE;
   assign trdyOe      = tgtState_ff != TS_IDLE;

////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         parCalc_ff  <= 1'b0;
         parDrive_ff <= 1'b0;
      end
      else
      begin
         parCalc_ff  <= ^{adOut, cbeOut};
         parDrive_ff <= adOe && cbeOe || tgtDrvData;
      end
   end
   assign parOut = parCalc_ff;
   assign parOe  = parDrive_ff;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         parCheck_ff <= 1'b0;
         perr_ff     <= 1'b0;
         perrOe_ff   <= 1'b0;
      end
      else
      begin
         parCheck_ff <= curPar;
         perr_ff     <= tgtWstb && (parIn != parCheck_ff) && cmdReg[`PERR_RESP_BIT];
         perrOe_ff   <= (tgtState_ff == TS_TURN) && tgtWrite_ff && cmdReg[`PERR_RESP_BIT];
      end
   end
   assign perrOut_n = !perr_ff;
   assign perrOe    = perrOe_ff || perr_ff;

////////////////////////////////////////////////////////////////////////////////

   property p_req_pend;
      @(posedge mclk) disable iff (!nrst) (mstStart && !mstBusy) |=> !req_n;
   endproperty
   a_req_pend: assert property (p_req_pend) else $error("request not raised");

   property p_abort;
      @(posedge mclk) disable iff (!nrst)
         (mstState_ff == ST_ADDR) ##1 (devselIn_n [*6]) |=> ##1 mstAbort;
   endproperty
   a_abort: assert property (p_abort) else $error("no initiator abort");

   property p_par_late;
      @(posedge mclk) disable iff (!nrst)
         (adOe && cbeOe) |=> (parOe && parOut == $past(^{adOut, cbeOut}));
   endproperty
   a_par_late: assert property (p_par_late) else $error("parity timing wrong");

   property p_perr_en;
      @(posedge mclk) disable iff (!nrst) !perrOut_n |-> $past(cmdReg[`PERR_RESP_BIT]);
   endproperty
   a_perr_en: assert property (p_perr_en) else $error("parity error not enabled");

   property p_claim;
      @(posedge mclk) disable iff (!nrst) hit |=> (!devselOut_n && devselOe);
   endproperty
   a_claim: assert property (p_claim) else $error("decoded cycle not claimed");

   property p_frame;
      @(posedge mclk) disable iff (!nrst)
         (mstState_ff == ST_IDLE && pend_ff && !gnt_n && busIdle && tgtState_ff == TS_IDLE)
         |=> (!frameOut_n && frameOe);
   endproperty
   a_frame: assert property (p_frame) else $error("frame not asserted");

   property p_done;
      @(posedge mclk) disable iff (!nrst) mstDone |-> $past(!trdyIn_n && !irdyOut_n);
   endproperty
   a_done: assert property (p_done) else $error("done without both ready");

   property p_lock;
      @(posedge mclk) disable iff (!nrst) multifunction_pin_7Oe |-> lockMode;
   endproperty
   a_lock: assert property (p_lock) else $error("lock driven when not routed");

endmodule : pci_primary_agent

//--- testbench/pci_far_agent.sv
// Far-side bus model: arbiter grant plus a one-phase memory target.
`timescale 1ns/100ps
module pci_far_agent (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        frame_n,
   input  wire logic        irdy_n,
   input  wire logic        req_n,
   input  wire logic [31:0] ad,
   input  wire logic [3:0]  cbe,
   input  wire logic        claimEn,
   input  wire logic        parkEn,
   input  wire logic        slowEn,
   input  wire logic [31:0] rdData,
   output logic             gnt_n,
   output logic             devsel_n,
   output logic             trdy_n,
   output logic             farAdOe,
   output logic             farParOe,
   output logic             farPar,
   output logic [31:0]      wrData,
   output logic [3:0]       wrBe
);
   logic       sel_ff;
   logic       wr_ff;
   logic       frame_ff;
   logic [1:0] cnt_ff;
   ////////////////////////////////////////////////////////////////
   // grant, parked grant.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         gnt_n <= 1'b1;
      else
         gnt_n <= !(parkEn || !req_n);
   end
   // claim a new frame, finish on both ready.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         sel_ff   <= 1'b0;
         wr_ff    <= 1'b0;
         frame_ff <= 1'b1;
         cnt_ff   <= 2'h0;
      end
      else
      begin
         frame_ff <= frame_n;
         if (!sel_ff && !frame_n && frame_ff && claimEn)
         begin
            sel_ff <= 1'b1;
            wr_ff  <= cbe[0];
            cnt_ff <= 2'h0;
         end
         else if (sel_ff && !trdy_n && !irdy_n)
         begin
            sel_ff <= 1'b0;
            wrData <= ad;
            wrBe   <= cbe;
         end
         else if (sel_ff && cnt_ff != 2'h3)
            cnt_ff <= cnt_ff + 2'h1;
      end
   end
   // parity trails the read data by one clock.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         farParOe <= 1'b0;
      else
      begin
         farParOe <= farAdOe;
         farPar   <= ^{rdData, cbe};
      end
   end
   // Slow mode holds ready back three clocks to force wait states.
   assign devsel_n = !sel_ff;
   assign trdy_n   = !(sel_ff && (!slowEn || cnt_ff == 2'h3));
   assign farAdOe  = sel_ff && !wr_ff;
endmodule : pci_far_agent

//--- testbench/pci_primary_bus_agent_signals_tb_top.sv
// Self-checking bench for the primary bus agent.
`timescale 1ns/100ps
`include "pci_agent_map.svh"
module pci_primary_bus_agent_signals_tb_top;
   logic [31:0] adIn, adOut, mstAddr, mstWdata, mstRdata, tgtWdata, tgtRdata;
   logic [31:0] tbAd, adLast, rdData, wrData, wsData;
   logic [15:0] cmdReg;
   logic [3:0]  cbeIn, cbeOut, tgtBe, mstCmd, mstBe, mfp7Route, tbCbe, wrBe, wsBe;
   logic adOe, cbeOe, parIn, parOut, parOe, frameIn_n, frameOut_n, frameOe;
   logic irdyIn_n, irdyOut_n, irdyOe, trdyIn_n, trdyOut_n, trdyOe, devselIn_n;
   logic devselOut_n, devselOe, perrOut_n, perrOe, req_n, gnt_n, mstStart;
   logic multifunction_pin_7In, multifunction_pin_7Out, multifunction_pin_7Oe;
   logic mstLockReq, mstBusy, mstDone, mstAbort, tgtWstb, lockHeld, mclk, nrst;
   logic tbDrv, tbFrame_n, tbIrdy_n, tbPar, claimEn, parkEn, slowEn;
   logic pDevsel_n, pTrdy_n, pAdOe, pParOe, pPar;
   int   mismatches, checked, dsCnt, wsCnt, peCnt, lkCnt, rqCnt;
   pci_primary_agent dut_u (.*);
   pci_far_agent far_u (.mclk(mclk), .nrst(nrst), .frame_n(frameIn_n),
      .irdy_n(irdyIn_n), .req_n(req_n), .ad(adIn), .cbe(cbeIn), .claimEn(claimEn),
      .parkEn(parkEn), .slowEn(slowEn), .rdData(rdData), .gnt_n(gnt_n),
      .devsel_n(pDevsel_n), .trdy_n(pTrdy_n), .farAdOe(pAdOe), .farParOe(pParOe),
      .farPar(pPar), .wrData(wrData), .wrBe(wrBe));
   ////////////////////////////////////////////////////////////////
   // Wire levels; undriven data shows the inverse of its last value.
   assign adIn = adOe ? adOut : pAdOe ? rdData : tbDrv ? tbAd : ~adLast;
   assign cbeIn = cbeOe ? cbeOut : tbDrv ? tbCbe : 4'hf;
   assign parIn = parOe ? parOut : pParOe ? pPar : tbDrv ? tbPar : 1'b1;
   assign frameIn_n = frameOe ? frameOut_n : tbFrame_n;
   assign irdyIn_n = irdyOe ? irdyOut_n : tbIrdy_n;
   assign trdyIn_n = trdyOe ? trdyOut_n : pTrdy_n;
   assign devselIn_n = devselOe ? devselOut_n : pDevsel_n;
   assign multifunction_pin_7In = multifunction_pin_7Oe ? multifunction_pin_7Out : 1'b1;
   always #5 mclk = ~mclk;
   // Event counters, so short pulses are never missed.
   always @(posedge mclk)
   begin
      adLast <= adIn;
      if (devselOe === 1'b1 && devselOut_n === 1'b0) dsCnt++;
      if (perrOe === 1'b1 && perrOut_n === 1'b0) peCnt++;
      if (multifunction_pin_7Oe === 1'b1 && multifunction_pin_7Out === 1'b0) lkCnt++;
      if (req_n === 1'b0) rqCnt++;
      if (tgtWstb === 1'b1) wsCnt++;
      if (tgtWstb === 1'b1) wsData <= tgtWdata;
      if (tgtWstb === 1'b1) wsBe <= tgtBe;
   end
   ////////////////////////////////////////////////////////////////
   task report_and_stop();
      $display("Mismatches %0d, checks %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task tmo(input int n);
      if (n >= 20)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: wait ran out", $time);
         report_and_stop();
      end
   endtask : tmo
   // One initiator transfer by the agent, checked at the wire.
   task mstXfer(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b, input logic abt);
      int n;
      mstStart = 1'b1;
      mstCmd = c;
      mstAddr = a;
      mstBe = b;
      @(negedge mclk);
      mstStart = 1'b0;
      for (n = 0; n < 20 && !(frameOe === 1'b1 && frameOut_n === 1'b0); n++) @(negedge mclk);
      tmo(n);
      chk(adIn, a);
      chk(cbeIn, c);
      @(negedge mclk);
      chk(parIn, ^{a, c});
      chk(cbeIn, b);
      chk(frameIn_n, 1'b1);
      for (n = 0; n < 20 && mstDone !== 1'b1 && mstAbort !== 1'b1; n++) @(negedge mclk);
      tmo(n);
      chk(mstAbort, abt);
      repeat (3) @(negedge mclk);
   endtask : mstXfer
   // One write from a foreign initiator towards the agent.
   task tgtCycle(input logic [31:0] a, input logic [3:0] c, input logic bad, input logic hit,
                 input logic pe);
      int n, d0, s0, p0;
      d0 = dsCnt;
      s0 = wsCnt;
      p0 = peCnt;
      tbDrv = 1'b1;
      tbFrame_n = 1'b0;
      tbAd = a;
      tbCbe = c;
      @(negedge mclk);
      tbFrame_n = 1'b1;
      tbIrdy_n = 1'b0;
      tbAd = 32'hc33c_5aa5;
      tbCbe = 4'h9;
      tbPar = ^{a, c};
      for (n = 0; n < 4 && trdyIn_n !== 1'b0; n++) @(negedge mclk);
      @(negedge mclk);
      tbIrdy_n = 1'b1;
      tbPar = ^{32'hc33c_5aa5, 4'h9} ^ bad;
      @(negedge mclk);
      tbDrv = 1'b0;
      repeat (5) @(negedge mclk);
      chk(dsCnt != d0, hit);
      chk(wsCnt - s0, hit);
      if (hit) chk(wsData, 32'hc33c_5aa5);
      if (hit) chk(wsBe, 4'h9);
      chk(peCnt != p0, pe);
   endtask : tgtCycle
   ////////////////////////////////////////////////////////////////
   task scnWrite();
      int r0;
      r0 = rqCnt;
      claimEn = 1'b1;
      mstWdata = 32'ha5c3_3c5a;
      mstXfer(`CMD_MEM_WRITE, 32'h1234_5670, 4'h6, 1'b0);
      chk(wrData, 32'ha5c3_3c5a);
      chk(wrBe, 4'h6);
      chk(rqCnt != r0, 1'b1);
   endtask : scnWrite
   task scnRead();
      parkEn = 1'b1;
      slowEn = 1'b1;
      rdData = 32'h0f1e_2d3c;
      mstXfer(`CMD_MEM_READ, 32'h0000_4444, 4'h0, 1'b0);
      chk(mstRdata, 32'h0f1e_2d3c);
      parkEn = 1'b0;
      slowEn = 1'b0;
   endtask : scnRead
   task scnAbort();
      claimEn = 1'b0;
      mstXfer(`CMD_IO_WRITE, 32'h0000_0300, 4'h1, 1'b1);
   endtask : scnAbort
   task scnTarget();
      cmdReg = 16'h0040;
      tgtCycle(32'h8000_0ab0, `CMD_MEM_WRITE, 1'b1, 1'b1, 1'b1);
      tgtCycle(32'h8000_0ab4, `CMD_MEM_WRITE, 1'b0, 1'b1, 1'b0);
      tgtCycle(32'h0000_1000, `CMD_MEM_WRITE, 1'b0, 1'b0, 1'b0);
      tgtCycle(32'h8000_0ab0, `CMD_CFG_WRITE, 1'b0, 1'b0, 1'b0);
      cmdReg = 16'h0000;
      tgtCycle(32'h8000_0ab8, `CMD_MEM_WRITE, 1'b1, 1'b1, 1'b0);
   endtask : scnTarget
   task scnLock();
      int l0;
      claimEn = 1'b1;
      mstLockReq = 1'b1;
      mfp7Route = `MFP7_ROUTE_LOCK;
      l0 = lkCnt;
      mstXfer(`CMD_MEM_WRITE, 32'h0000_0040, 4'h0, 1'b0);
      chk(lkCnt != l0, 1'b1);
      mfp7Route = 4'h0;
      repeat (2) @(negedge mclk);
      l0 = lkCnt;
      mstXfer(`CMD_MEM_WRITE, 32'h0000_0044, 4'h0, 1'b0);
      chk(lkCnt - l0, 0);
      mstLockReq = 1'b0;
   endtask : scnLock
   // Main sequence; inputs change only on falling edges.
   initial
   begin
      {mclk, nrst, mstStart, mstCmd, mstAddr, mstWdata, mstBe, mstLockReq} = '0;
      {mfp7Route, cmdReg, tbDrv, tbAd, tbCbe, tbPar, claimEn, parkEn, slowEn} = '0;
      {tgtRdata, rdData, adLast, mismatches, checked} = '0;
      {dsCnt, wsCnt, peCnt, lkCnt, rqCnt} = '0;
      tbFrame_n = 1'b1;
      tbIrdy_n = 1'b1;
      repeat (20) @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      scnWrite();
      scnRead();
      scnAbort();
      scnTarget();
      scnLock();
      report_and_stop();
   end
endmodule : pci_primary_bus_agent_signals_tb_top
